// file: tsq_pkg.sv
`default_nettype none
package tsq_pkg;
  localparam int NUM_TERMS = 8;
  localparam int TERM_W    = 3;
  localparam int CNT_W     = 16;
  localparam int RES_W     = 10;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 32;
  // resource vector: bits 3:0 patterns 1-4, bit 4 range, bits 8:5 patterns 5-8, bit 9 arm
  localparam int RES_RANGE = 4;
  localparam int RES_ARM   = 9;
  // qualifier expression word layout
  localparam int QX_S1_MASK_LSB = 0;   // 5 bits
  localparam int QX_S1_NOR      = 5;
  localparam int QX_S2_MASK_LSB = 6;   // 5 bits
  localparam int QX_S2_NOR      = 11;
  localparam int QX_OP_OR       = 12;  // 0 and, 1 or
  localparam int QX_S1_USE      = 13;
  localparam int QX_S2_USE      = 14;
  localparam int QX_W           = 15;
  localparam logic [QX_W-1:0] QX_NEVER = 15'h0000;
  localparam logic [QX_W-1:0] QX_ANY   = 15'h1020;  // set 1 nor of nothing = true, or
  // address map (word offsets on the plain port)
  localparam logic [ADDR_W-1:0] A_PRI_EXPR  = 6'h00;  // +term
  localparam logic [ADDR_W-1:0] A_PRI_DEST  = 6'h08;
  localparam logic [ADDR_W-1:0] A_PRI_CNT   = 6'h10;
  localparam logic [ADDR_W-1:0] A_SEC_EXPR  = 6'h18;
  localparam logic [ADDR_W-1:0] A_SEC_DEST  = 6'h20;
  localparam logic [ADDR_W-1:0] A_STO       = 6'h28;
  localparam logic [ADDR_W-1:0] A_STO_ALL   = 6'h30;
  localparam logic [ADDR_W-1:0] A_TRIG_TERM = 6'h31;
  localparam logic [ADDR_W-1:0] A_PRESTORE  = 6'h32;
  localparam logic [ADDR_W-1:0] A_CTRL      = 6'h33;  // bit0 reset, bit1 restart
  localparam logic [ADDR_W-1:0] A_SIMPLE    = 6'h34;
  localparam logic [ADDR_W-1:0] A_STATUS    = 6'h35;
  localparam logic [TERM_W-1:0] TRIG_RESET  = 3'h1;   // second term, zero based
  localparam logic [CNT_W-1:0]  CNT_RESET   = 16'h0001;
  // storage qualifier codes
  localparam logic [1:0] STO_ALL  = 2'h0;
  localparam logic [1:0] STO_NONE = 2'h1;
  localparam logic [1:0] STO_PAT  = 2'h2;  // pattern resource selected by index
  localparam logic [1:0] STO_RNG  = 2'h3;
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] pat;
  } tsq_sto_s;
  typedef struct packed {
    logic              valid;
    logic [RES_W-1:0]  res;
  } tsq_state_s;
endpackage : tsq_pkg
`default_nettype wire

// file: tsq_sequencer.sv
// Design decisions made here: the plain strobed port and the register addresses.
`default_nettype none
module tsq_sequencer #(
  parameter int NUM_TERMS = tsq_pkg::NUM_TERMS
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire tsq_pkg::tsq_state_s         state_in,
  input  wire logic [tsq_pkg::ADDR_W-1:0]  addr,
  input  wire logic [tsq_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic [tsq_pkg::DATA_W-1:0]       rdata,
  output logic                             store,
  output logic                             prestore,
  output logic                             trigger,
  output logic [tsq_pkg::TERM_W-1:0]       term
);
  localparam int TW = tsq_pkg::TERM_W;
  localparam int QW = tsq_pkg::QX_W;
  localparam int CW = tsq_pkg::CNT_W;

  // the branch and destination fields are three bits wide, so only eight terms fit
  if (NUM_TERMS != 8) begin : g_bad_terms
    $error("sequencer needs exactly eight terms");
  end

  typedef enum logic [1:0] {
    TSQ_IDLE = 2'b01,
    TSQ_RUN  = 2'b10
  } tsq_run_e;

  // set evaluation: or/nor within a set, then and/or across
  function automatic logic qx_eval(input logic [QW-1:0] x,
                                   input logic [tsq_pkg::RES_W-1:0] r);
    logic s1;
    logic s2;
    s1 = |(x[tsq_pkg::QX_S1_MASK_LSB +: 5] & r[4:0]);
    s2 = |(x[tsq_pkg::QX_S2_MASK_LSB +: 5] & r[9:5]);
    if (x[tsq_pkg::QX_S1_NOR]) s1 = ~s1;
    if (x[tsq_pkg::QX_S2_NOR]) s2 = ~s2;
    if (!x[tsq_pkg::QX_S1_USE]) s1 = x[tsq_pkg::QX_OP_OR] ? 1'b0 : 1'b1;
    if (!x[tsq_pkg::QX_S2_USE]) s2 = x[tsq_pkg::QX_OP_OR] ? 1'b0 : 1'b1;
    if (!x[tsq_pkg::QX_S1_USE] && !x[tsq_pkg::QX_S2_USE]) begin
      qx_eval = x[tsq_pkg::QX_S1_NOR]; // any when nor set, never otherwise
    end else begin
      qx_eval = x[tsq_pkg::QX_OP_OR] ? (s1 | s2) : (s1 & s2);
    end
  endfunction : qx_eval

  function automatic logic sto_eval(input tsq_pkg::tsq_sto_s s,
                                    input logic [tsq_pkg::RES_W-1:0] r);
    logic [2:0] p;
    p = s.pat;
    unique case (s.mode)
      tsq_pkg::STO_ALL:  sto_eval = 1'b1;
      tsq_pkg::STO_NONE: sto_eval = 1'b0;
      tsq_pkg::STO_PAT:  sto_eval = p[2] ? r[5 + p[1:0]] : r[p[1:0]];
      tsq_pkg::STO_RNG:  sto_eval = r[tsq_pkg::RES_RANGE];
    endcase
  endfunction : sto_eval

  logic [QW-1:0]         pri_x_q  [NUM_TERMS];
  logic [TW-1:0]         pri_d_q  [NUM_TERMS];
  logic [CW-1:0]         pri_c_q  [NUM_TERMS];
  logic [QW-1:0]         sec_x_q  [NUM_TERMS];
  logic [TW-1:0]         sec_d_q  [NUM_TERMS];
  tsq_pkg::tsq_sto_s     sto_q    [NUM_TERMS];
  logic [TW-1:0]         trig_t_q;
  logic [QW-1:0]         pre_x_q;
  logic [CW-1:0]         occ_q;
  tsq_run_e              run_q;
  logic [TW-1:0]         term_q;
  logic                  trig_q;
  logic                  store_q;
  logic                  pre_q;
  logic [tsq_pkg::DATA_W-1:0] rdata_q;

  wire       seq_reset  = wr && addr == tsq_pkg::A_CTRL && wdata[0];
  wire       seq_start  = wr && addr == tsq_pkg::A_CTRL && wdata[1];
  wire       simple_wr  = wr && addr == tsq_pkg::A_SIMPLE;
  wire [2:0] wsel       = addr[2:0];
  wire [2:0] grp        = addr[5:3];
  wire       pri_hit    = qx_eval(pri_x_q[term_q], state_in.res);
  wire       sec_hit    = qx_eval(sec_x_q[term_q], state_in.res);
  wire       live       = run_q == TSQ_RUN && state_in.valid;
  wire       pri_fire   = live && pri_hit && occ_q <= 16'h0001;
  wire       sec_fire   = live && !pri_hit && sec_hit;
  wire [TW-1:0] next_t  = pri_fire ? pri_d_q[term_q] : sec_d_q[term_q];
  wire       branch     = pri_fire || sec_fire;

  genvar g;
  generate
    for (g = 0; g < NUM_TERMS; g++) begin : g_term
      localparam logic [TW-1:0] NXT = TW'(g + 1);
      wire sel = wsel == TW'(g);
      always_ff @(posedge clk) begin
        if (rst || seq_reset) begin
          pri_x_q[g] <= (g == NUM_TERMS - 1) ? tsq_pkg::QX_NEVER : tsq_pkg::QX_ANY;
          pri_d_q[g] <= NXT;
          pri_c_q[g] <= tsq_pkg::CNT_RESET;
          sec_x_q[g] <= tsq_pkg::QX_NEVER;
          sec_d_q[g] <= '0;
          sto_q[g]   <= '{mode: tsq_pkg::STO_ALL, pat: 3'h0};
        end else begin
          if (simple_wr && g == 0) begin
            pri_x_q[g] <= wdata[QW-1:0];
            pri_d_q[g] <= 3'h1;
            sec_x_q[g] <= tsq_pkg::QX_NEVER;
          end else if (simple_wr && g == 1) begin
            pri_x_q[g] <= tsq_pkg::QX_NEVER;
            sec_x_q[g] <= tsq_pkg::QX_NEVER;
          end else if (wr && sel) begin
            if (grp == 3'h0) pri_x_q[g] <= wdata[QW-1:0];
            if (grp == 3'h1) pri_d_q[g] <= wdata[TW-1:0];
            if (grp == 3'h2) pri_c_q[g] <= wdata[CW-1:0];
            if (grp == 3'h3) sec_x_q[g] <= wdata[QW-1:0];
            if (grp == 3'h4) sec_d_q[g] <= wdata[TW-1:0];
            if (grp == 3'h5) sto_q[g]   <= wdata[4:0];
          end
          if (wr && addr == tsq_pkg::A_STO_ALL) sto_q[g] <= wdata[4:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || seq_reset) begin
      trig_t_q <= tsq_pkg::TRIG_RESET;
      pre_x_q  <= tsq_pkg::QX_NEVER;
    end else if (simple_wr) begin
      trig_t_q <= 3'h1;
    end else if (wr && addr == tsq_pkg::A_TRIG_TERM && wdata[TW-1:0] != 3'h0) begin
      trig_t_q <= wdata[TW-1:0];
    end else if (wr && addr == tsq_pkg::A_PRESTORE) begin
      pre_x_q  <= wdata[QW-1:0];
    end
  end

  // counting the current term's primary matches; reloaded on every entry
  always_ff @(posedge clk) begin
    if (rst || seq_reset) begin
      run_q  <= TSQ_IDLE;
      term_q <= '0;
      occ_q  <= tsq_pkg::CNT_RESET;
      trig_q <= 1'b0;
    end else if (seq_start) begin
      run_q  <= TSQ_RUN;
      term_q <= '0;
      occ_q  <= pri_c_q[0];
      trig_q <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (branch) begin
        term_q <= next_t;
        occ_q  <= pri_c_q[next_t];
        trig_q <= next_t == trig_t_q;
      end else if (live && pri_hit) begin
        occ_q  <= occ_q - 16'h0001;
      end
    end
  end

  // store decision follows the term that was searching when the state came
  always_ff @(posedge clk) begin
    if (rst) begin
      store_q <= 1'b0;
      pre_q   <= 1'b0;
    end else begin
      store_q <= live && sto_eval(sto_q[term_q], state_in.res);
      pre_q   <= live && !sto_eval(sto_q[term_q], state_in.res)
                 && qx_eval(pre_x_q, state_in.res);
    end
  end

  wire [tsq_pkg::DATA_W-1:0] rd_mux =
      addr == tsq_pkg::A_SIMPLE    ? 32'(pri_x_q[0]) :
      addr == tsq_pkg::A_TRIG_TERM ? 32'(trig_t_q) :
      addr == tsq_pkg::A_PRESTORE  ? 32'(pre_x_q) :
      addr == tsq_pkg::A_STATUS    ? 32'({run_q == TSQ_RUN, occ_q, term_q}) :
      grp == 3'h0 ? 32'(pri_x_q[wsel]) :
      grp == 3'h1 ? 32'(pri_d_q[wsel]) :
      grp == 3'h2 ? 32'(pri_c_q[wsel]) :
      grp == 3'h3 ? 32'(sec_x_q[wsel]) :
      grp == 3'h4 ? 32'(sec_d_q[wsel]) :
      grp == 3'h5 ? 32'(sto_q[wsel]) : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) rdata_q <= '0;
    else     rdata_q <= rd ? rd_mux : 32'h0000_0000;
  end

  assign rdata    = rdata_q;
  assign store    = store_q;
  assign prestore = pre_q;
  assign trigger  = trig_q;
  assign term     = term_q;

  trig_entry_a: assert property (@(posedge clk) disable iff (rst)
    trigger |-> term == trig_t_q) else $error("trigger without trigger term");
  trig_never_one_a: assert property (@(posedge clk) disable iff (rst)
    trig_t_q != 3'h0) else $error("term one selected as trigger");
  prim_wins_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    pri_fire |=> term == $past(pri_d_q[term_q])) else $error("primary branch lost");
  never_hold_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    (pri_x_q[term_q] == 15'h0000 && sec_x_q[term_q] == 15'h0000) |=> $stable(term))
    else $error("left a never term");
  reset_trig_a: assert property (@(posedge clk)
    rst |=> trig_t_q == 3'h1) else $error("trigger term default wrong");
  store_all_a: assert property (@(posedge clk) disable iff (rst)
    (live && sto_q[term_q].mode == 2'h0) |=> store) else $error("store all missed");
  store_none_a: assert property (@(posedge clk) disable iff (rst)
    (sto_q[term_q].mode == 2'h1) |=> !store) else $error("store none stored");
  simple_a: assert property (@(posedge clk) disable iff (rst)
    simple_wr |=> trig_t_q == 3'h1 && pri_d_q[0] == 3'h1) else $error("simple trigger");

  // named steps of a branch, the count and the idle state, used by the properties below
  sequence s_pri_take;
    pri_fire;
  endsequence

  sequence s_sec_take;
    sec_fire;
  endsequence

  sequence s_enter_trig;
    branch && next_t == trig_t_q;
  endsequence

  sequence s_trig_pulse;
    trigger;
  endsequence

  sequence s_count_down;
    live && pri_hit && occ_q > 16'h0001;
  endsequence

  sequence s_idle_cycle;
    run_q == TSQ_IDLE;
  endsequence

  sequence s_quiet_out;
    !store && !prestore && !trigger;
  endsequence

  pri_dest_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    s_pri_take |=> term == $past(pri_d_q[term_q])) else $error("primary went astray");

  sec_dest_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    s_sec_take |=> term == $past(sec_d_q[term_q])) else $error("secondary went astray");

  trig_raise_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    s_enter_trig |=> s_trig_pulse) else $error("trigger missed on entry");

  count_step_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    s_count_down |=> occ_q == $past(occ_q) - 16'h0001) else $error("occurrence count slipped");

  idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
    s_idle_cycle |=> s_quiet_out) else $error("idle sequencer produced output");

  hold_term_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    !branch |=> $stable(term)) else $error("term moved without a branch");

  pre_only_a: assert property (@(posedge clk) disable iff (rst)
    prestore |-> !store) else $error("prestore on a stored state");

  pre_none_a: assert property (@(posedge clk) disable iff (rst)
    (pre_x_q == tsq_pkg::QX_NEVER) |=> !prestore)
    else $error("prestore with never expression");

  store_rng_a: assert property (@(posedge clk) disable iff (rst)
    (live && sto_q[term_q].mode == tsq_pkg::STO_RNG && state_in.res[tsq_pkg::RES_RANGE])
    |=> store) else $error("range state not stored");

  pat_store_a: assert property (@(posedge clk) disable iff (rst)
    (live && sto_q[term_q].mode == tsq_pkg::STO_PAT && state_in.res == 10'h000)
    |=> !store) else $error("pattern store without match");

  rd_zero_a: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 32'h0000_0000) else $error("read data outside its cycle");

  simple_rd_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == tsq_pkg::A_SIMPLE) |=> rdata == 32'($past(pri_x_q[0])))
    else $error("simple trigger read wrong");

  trig_keep_a: assert property (@(posedge clk) disable iff (rst || seq_reset)
    (wr && addr == tsq_pkg::A_TRIG_TERM && wdata[TW-1:0] == 3'h0) |=> $stable(trig_t_q))
    else $error("term one accepted as trigger");

  dest_write_a: assert property (@(posedge clk) disable iff (rst || seq_reset)
    (wr && grp == 3'h1) |=> pri_d_q[$past(wsel)] == $past(wdata[TW-1:0]))
    else $error("primary destination not written");

  reset_pri_a: assert property (@(posedge clk)
    rst |=> pri_x_q[0] == tsq_pkg::QX_ANY && pri_x_q[NUM_TERMS-1] == tsq_pkg::QX_NEVER)
    else $error("primary defaults wrong");

  seq_reset_a: assert property (@(posedge clk) disable iff (rst)
    seq_reset |=> trig_t_q == tsq_pkg::TRIG_RESET && run_q == TSQ_IDLE && term == 3'h0)
    else $error("sequencer reset incomplete");

  // helper: cycles spent in a term whose branches are both never; saturates, never wraps
  logic [7:0] stuck_q;
  wire        stuck_term = run_q == TSQ_RUN && pri_x_q[term_q] == tsq_pkg::QX_NEVER
                           && sec_x_q[term_q] == tsq_pkg::QX_NEVER;

  always_ff @(posedge clk) begin
    if (rst || seq_reset || seq_start || !stuck_term) stuck_q <= 8'h00;
    else if (stuck_q != 8'hFF)                         stuck_q <= stuck_q + 8'h01;
  end

  stuck_hold_a: assert property (@(posedge clk) disable iff (rst || seq_reset || seq_start)
    stuck_q != 8'h00 |-> $stable(term)) else $error("never term released");

  // per-term checks; a broadcast must reach every term, not just the addressed one
  generate
    for (g = 0; g < NUM_TERMS; g++) begin : g_term_chk
      sto_all_a: assert property (@(posedge clk) disable iff (rst || seq_reset)
        (wr && addr == tsq_pkg::A_STO_ALL) |=> sto_q[g] == $past(wdata[4:0]))
        else $error("storage broadcast missed a term");
      term_dflt_a: assert property (@(posedge clk) disable iff (rst)
        seq_reset |=> sec_x_q[g] == tsq_pkg::QX_NEVER && sto_q[g].mode == tsq_pkg::STO_ALL
        && pri_c_q[g] == tsq_pkg::CNT_RESET) else $error("term defaults not restored");
    end
  endgenerate
endmodule : tsq_sequencer
`default_nettype wire

// file: tsq_bus_src.sv
`default_nettype none
module tsq_bus_src (
  input  wire logic           clk,
  output var tsq_pkg::tsq_state_s state_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial state_out = '0;
  // one state per call; between states the lines carry the inverse so stale data never matches
  task automatic send(input logic [tsq_pkg::RES_W-1:0] res);
    @(posedge clk);
    state_out <= '{valid: 1'b1, res: res};
    @(posedge clk);
    state_out <= '{valid: 1'b0, res: ~res};
  endtask : send
endmodule : tsq_bus_src
`default_nettype wire

// file: tb_trace_sequencer_eight_term.sv
`default_nettype none
module tb_trace_sequencer_eight_term;
  timeunit 1ns;
  timeprecision 1ns;
  logic                          clk = 1'b0;
  logic                          rst = 1'b1;
  logic [tsq_pkg::ADDR_W-1:0]    addr = '0;
  logic [tsq_pkg::DATA_W-1:0]    wdata = '0;
  logic                          wr = 1'b0;
  logic                          rd = 1'b0;
  logic [tsq_pkg::DATA_W-1:0]    rdata;
  logic                          store;
  logic                          prestore;
  logic                          trigger;
  logic [tsq_pkg::TERM_W-1:0]    term;
  tsq_pkg::tsq_state_s           st;
  int                            num_errors = 0;
  int                            n_tests = 0;
  always #50 clk = ~clk;
  tsq_bus_src u_src (.clk(clk), .state_out(st));
  tsq_sequencer u_dut (.clk(clk), .rst(rst), .state_in(st), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .store(store), .prestore(prestore),
    .trigger(trigger), .term(term));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_chk
  // one state, then term, store, trigger and prestore as they stand after it is taken
  task automatic step(input logic [9:0] res, input logic [2:0] t, input logic [2:0] stp);
    u_src.send(res);
    #1;
    chk("seq", {26'h0, t, stp}, {26'h0, term, store, trigger, prestore});
  endtask : step
  task automatic chk_defaults;
    for (int t = 0; t < 8; t++) begin
      rd_chk(6'(t), (t < 7) ? 32'(tsq_pkg::QX_ANY) : 32'h0);
      rd_chk(6'(8 + t), 32'((t + 1) % 8));
      rd_chk(6'(16 + t), 32'(tsq_pkg::CNT_RESET));
      rd_chk(6'(24 + t), 32'h0);
      rd_chk(6'(40 + t), 32'h0);
    end
    rd_chk(tsq_pkg::A_TRIG_TERM, 32'h1);
  endtask : chk_defaults
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_defaults();
    wr_reg(tsq_pkg::A_CTRL, 32'h2);
    step(10'h0, 3'h1, 3'b110);
    for (int t = 2; t < 8; t++) step(10'h0, 3'(t), 3'b100);
    step(10'h0, 3'h7, 3'b100);
    wr_reg(tsq_pkg::A_TRIG_TERM, 32'h0);
    rd_chk(tsq_pkg::A_TRIG_TERM, 32'h1);
    wr_reg(tsq_pkg::A_TRIG_TERM, 32'h7);
    rd_chk(tsq_pkg::A_TRIG_TERM, 32'h7);
    wr_reg(tsq_pkg::A_CTRL, 32'h1);
    chk_defaults();
    // simple trigger on pattern one
    wr_reg(tsq_pkg::A_SIMPLE, 32'h2001);
    rd_chk(tsq_pkg::A_SIMPLE, 32'h2001);
    rd_chk(tsq_pkg::A_PRI_DEST, 32'h1);
    rd_chk(tsq_pkg::A_SEC_EXPR, 32'h0);
    rd_chk(tsq_pkg::A_PRI_EXPR + 6'h1, 32'h0);
    rd_chk(tsq_pkg::A_SEC_EXPR + 6'h1, 32'h0);
    wr_reg(tsq_pkg::A_CTRL, 32'h2);
    step(10'h0, 3'h0, 3'b100);
    step(10'h1, 3'h1, 3'b110);
    step(10'h1, 3'h1, 3'b100);
    // window: term one stores nothing, term two stores all
    wr_reg(tsq_pkg::A_CTRL, 32'h1);
    wr_reg(tsq_pkg::A_STO_ALL, 32'h08);
    wr_reg(tsq_pkg::A_STO + 6'h1, 32'h0);
    wr_reg(tsq_pkg::A_STO + 6'h2, 32'h12);
    wr_reg(tsq_pkg::A_PRI_CNT, 32'h2);
    wr_reg(tsq_pkg::A_PRI_EXPR, 32'h2001);
    wr_reg(tsq_pkg::A_PRI_EXPR + 6'h1, 32'h2008);
    wr_reg(tsq_pkg::A_SEC_EXPR + 6'h1, 32'h2002);
    wr_reg(tsq_pkg::A_SEC_DEST + 6'h1, 32'h0);
    wr_reg(tsq_pkg::A_TRIG_TERM, 32'h2);
    rd_chk(tsq_pkg::A_STO + 6'h5, 32'h08);
    wr_reg(tsq_pkg::A_CTRL, 32'h2);
    step(10'h1, 3'h0, 3'b000);
    step(10'h0, 3'h0, 3'b000);
    step(10'h1, 3'h1, 3'b000);
    step(10'h0, 3'h1, 3'b100);
    step(10'h2, 3'h0, 3'b100);
    step(10'h1, 3'h0, 3'b000);
    step(10'h1, 3'h1, 3'b000);
    step(10'h00A, 3'h2, 3'b110);
    step(10'h004, 3'h3, 3'b100);
    // prestore on pattern eight, with term four storing nothing
    wr_reg(tsq_pkg::A_PRESTORE, 32'h4200);
    step(10'h100, 3'h4, 3'b001);
    step(10'h000, 3'h5, 3'b000);
    // term six stores by range and branches on the nor of arm
    wr_reg(tsq_pkg::A_STO + 6'h5, 32'h18);
    wr_reg(tsq_pkg::A_PRI_EXPR + 6'h5, 32'h4C00);
    step(10'h200, 3'h5, 3'b000);
    step(10'h010, 3'h6, 3'b100);
    rd_chk(tsq_pkg::A_STATUS, 32'h0008_000E);
    tally_and_finish();
  end
endmodule : tb_trace_sequencer_eight_term
`default_nettype wire
